/* File: logic/efr_map_crc.sv */
// Periodic CRC check over a snapshot of the register map contents
module efr_map_crc
    import efr_pkg::*;
#(
    parameter int MAP_W      = 64,             // Bits of map under check
    parameter int PERIOD_CYC = EFR_PERIOD_CYC  // Cycles between passes
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,       // Freezes all state when low
    input  wire logic             i_enable,   // Checking runs while high
    input  wire logic             i_map_wr,   // Legitimate map write
    input  wire logic [MAP_W-1:0] i_map,      // Live map contents
    output logic                  o_mismatch  // One-cycle: contents drifted
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT} efr_crc_st_e;

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam int IW = $clog2(MAP_W + 1);

    efr_crc_st_e      st_r,    st_nxt;     // Sequencer state
    logic [CW-1:0]    tmr_r,   tmr_nxt;    // Interval timer
    logic [IW-1:0]    idx_r,   idx_nxt;    // Bit being folded in
    logic [MAP_W-1:0] snap_r,  snap_nxt;   // Frozen copy of the map
    logic [7:0]       crc_r,   crc_nxt;    // Running CRC
    logic [7:0]       base_r,  base_nxt;   // Reference CRC
    logic             bval_r,  bval_nxt;   // Reference holds a valid value
    logic             dirty_r, dirty_nxt;  // Write seen during a pass
    logic             mis_r,   mis_nxt;    // Registered mismatch pulse
    logic             fb;                  // CRC feedback bit

    // Next-state logic for the checking sequence
    always_comb begin
        st_nxt    = st_r;
        tmr_nxt   = tmr_r;
        idx_nxt   = idx_r;
        snap_nxt  = snap_r;
        crc_nxt   = crc_r;
        base_nxt  = base_r;
        bval_nxt  = bval_r;
        dirty_nxt = dirty_r | i_map_wr;
        mis_nxt   = 1'b0;
        fb        = crc_r[7] ^ snap_r[MAP_W-1];
        // A write makes the old reference meaningless
        if (i_map_wr) begin
            bval_nxt = 1'b0;
        end
        case (st_r)
            ST_IDLE: begin
                dirty_nxt = 1'b0;
                if (i_enable) begin
                    st_nxt  = ST_WAIT;
                    tmr_nxt = CW'(PERIOD_CYC - 1);
                end
            end
            ST_WAIT: begin
                if (!i_enable) begin
                    st_nxt   = ST_IDLE;
                    bval_nxt = 1'b0;
                end else if (tmr_r == '0) begin
                    // Snapshot so a pass sees one consistent map
                    st_nxt    = ST_SHIFT;
                    snap_nxt  = i_map;
                    crc_nxt   = EFR_CRC_SEED;
                    idx_nxt   = '0;
                    dirty_nxt = i_map_wr;
                end else begin
                    tmr_nxt = tmr_r - CW'(1);
                end
            end
            ST_SHIFT: begin
                if (idx_r == IW'(MAP_W)) begin
                    st_nxt  = ST_WAIT;
                    tmr_nxt = CW'(PERIOD_CYC - 1);
                    if (dirty_r || i_map_wr || !bval_r) begin
                        // Writes re-baseline rather than raise an error
                        base_nxt = crc_r;
                        bval_nxt = !(dirty_r || i_map_wr);
                    end else if (crc_r != base_r) begin
                        mis_nxt = i_enable;
                    end
                    if (!i_enable) begin
                        st_nxt = ST_IDLE;
                    end
                end else begin
                    crc_nxt  = {crc_r[6:0], 1'b0} ^ (fb ? EFR_CRC_POLY : 8'h00);
                    snap_nxt = {snap_r[MAP_W-2:0], 1'b0};
                    idx_nxt  = idx_r + IW'(1);
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r    <= ST_IDLE;
            tmr_r   <= '0;
            idx_r   <= '0;
            snap_r  <= '0;
            crc_r   <= EFR_CRC_SEED;
            base_r  <= EFR_CRC_SEED;
            bval_r  <= 1'b0;
            dirty_r <= 1'b0;
            mis_r   <= 1'b0;
        end else if (i_ce) begin
            st_r    <= st_nxt;
            tmr_r   <= tmr_nxt;
            idx_r   <= idx_nxt;
            snap_r  <= snap_nxt;
            crc_r   <= crc_nxt;
            base_r  <= base_nxt;
            bval_r  <= bval_nxt;
            dirty_r <= dirty_nxt;
            mis_r   <= mis_nxt;
        end
    end

    assign o_mismatch = mis_r & i_ce;
endmodule : efr_map_crc

/* File: pkg/efr_pkg.sv */
// Constants shared by the error flag register and its integrity monitor
package efr_pkg;
    // Register placement and reset value
    localparam logic [7:0] EFR_ERR_ADDR  = 8'h06; // Error register address
    localparam int         EFR_FLAG_W    = 8;     // Flags kept in this block
    localparam logic [7:0] EFR_FLAG_RST  = 8'h00; // All flags clear at reset
    localparam int         EFR_REG_W     = 16;    // Full register width
    // Flag bit positions
    localparam int EFR_B_ROM_CRC  = 0;
    localparam int EFR_B_MAP_CRC  = 1;
    localparam int EFR_B_FRM_CRC  = 2;
    localparam int EFR_B_WR_ADDR  = 3;
    localparam int EFR_B_RD_ADDR  = 4;
    localparam int EFR_B_CLK_CNT  = 5;
    localparam int EFR_B_IGNORED  = 6;
    localparam int EFR_B_CONV     = 7;
    // Serial frames are built from whole bytes
    localparam logic [2:0] EFR_BYTE_MASK = 3'h7;
    // Register map integrity check
    localparam logic [7:0] EFR_CRC_POLY  = 8'h07; // x^8+x^2+x+1
    localparam logic [7:0] EFR_CRC_SEED  = 8'h00;
    localparam int         EFR_CLK_MHZ   = 10;    // System clock rate
    localparam int         EFR_PERIOD_US = 100;   // Time between checks
    localparam int         EFR_PERIOD_CYC = EFR_PERIOD_US * EFR_CLK_MHZ;
endpackage : efr_pkg

/* File: logic/efr_error_flags.sv */
// Sticky write-one-to-clear error flags, lower byte of the error register
// What this block does
// - Access during ignore period sets bit 6
// - Frame clock count not byte multiple: bit 5
// - Read of missing address sets bit 4
// - Write to missing address sets bit 3
// - Failed frame checksum sets bit 2
// - Periodic map CRC drift sets bit 1
// - Power-up ROM CRC failure sets bit 0
// - Clamp, calibration range, saturation set bit 7
// - Writing one clears; zero leaves flag
// - Flags act only when enabled
module efr_error_flags
    import efr_pkg::*;
#(
    parameter logic [7:0] LAST_ADDR  = 8'h1F,          // Highest valid address
    parameter int         MAP_W      = 64,             // Map bits under CRC
    parameter int         PERIOD_CYC = EFR_PERIOD_CYC  // Map check interval
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,           // Clock enable
    // Enables from the error enable register, low byte
    input  wire logic [EFR_FLAG_W-1:0] i_err_en,
    // Register port from the serial engine
    input  wire logic                  i_reg_wr,       // Register write pulse
    input  wire logic [7:0]            i_reg_addr,     // Register address
    input  wire logic [EFR_REG_W-1:0]  i_reg_wdata,    // Write data
    // Serial interface events
    input  wire logic                  i_access,       // Frame began
    input  wire logic                  i_ignoring,     // Accesses ignored now
    input  wire logic                  i_frame_end,    // Chip select released
    input  wire logic [2:0]            i_frame_bits,   // Clock count, low bits
    input  wire logic                  i_rd_cmd,       // Read command decoded
    input  wire logic                  i_wr_cmd,       // Write command decoded
    input  wire logic [7:0]            i_cmd_addr,     // Command address
    input  wire logic                  i_frame_crc_bad,// Frame checksum failed
    // Power-up ROM check result
    input  wire logic                  i_rom_crc_done, // Check finished pulse
    input  wire logic                  i_rom_crc_ok,   // Check passed
    // Conversion and calibration faults
    input  wire logic                  i_clamp_pos,    // Result at +full scale
    input  wire logic                  i_clamp_neg,    // Result at -full scale
    input  wire logic                  i_cal_range,    // Calibration out of range
    input  wire logic                  i_mod_sat,      // Modulator saturated
    // Register map contents for the integrity check
    input  wire logic [MAP_W-1:0]      i_map,
    // Flag outputs
    output logic [EFR_FLAG_W-1:0]      o_err_flags     // Current flags
);
    logic [EFR_FLAG_W-1:0] flag_r, flag_nxt; // Sticky flags
    logic [EFR_FLAG_W-1:0] evt;              // Raw events this cycle
    logic [EFR_FLAG_W-1:0] clr;              // Clear mask from the host
    logic                  map_mis;          // Map CRC drift pulse
    logic                  err_hit;          // Write targets this register

    // Map integrity monitor, runs only while its flag is enabled
    efr_map_crc #(
        .MAP_W      (MAP_W),
        .PERIOD_CYC (PERIOD_CYC)
    ) u_map_crc (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_enable   (i_err_en[EFR_B_MAP_CRC]),
        .i_map_wr   (i_reg_wr),
        .i_map      (i_map),
        .o_mismatch (map_mis)
    );

    // Collect events; the serial engine qualifies them with the frame
    always_comb begin
        evt = '0;
        evt[EFR_B_IGNORED] = i_access & i_ignoring;
        evt[EFR_B_CLK_CNT] = i_frame_end &
                             ((i_frame_bits & EFR_BYTE_MASK) != '0);
        evt[EFR_B_RD_ADDR] = i_rd_cmd & (i_cmd_addr > LAST_ADDR);
        evt[EFR_B_WR_ADDR] = i_wr_cmd & (i_cmd_addr > LAST_ADDR);
        evt[EFR_B_FRM_CRC] = i_frame_crc_bad;
        evt[EFR_B_MAP_CRC] = map_mis;
        evt[EFR_B_ROM_CRC] = i_rom_crc_done & ~i_rom_crc_ok;
        evt[EFR_B_CONV]    = i_clamp_pos | i_clamp_neg |
                             i_cal_range | i_mod_sat;
    end

    // Host clear and sticky update
    always_comb begin
        err_hit = i_reg_wr & (i_reg_addr == EFR_ERR_ADDR);
        // Only ones clear; zeros in the write data leave flags alone
        clr = err_hit ? i_reg_wdata[EFR_FLAG_W-1:0] : '0;
        // Set wins over clear so a coincident event is never lost
        flag_nxt = (flag_r & ~clr) | (evt & i_err_en);
    end

    // Flag register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_r <= EFR_FLAG_RST;
        end else if (i_ce) begin
            flag_r <= flag_nxt;
        end
    end

    assign o_err_flags = flag_r;
endmodule : efr_error_flags

/* File: bench/efr_error_flags_assertions.sv */
// Concurrent checks on the error flag register ports
module efr_error_flags_chk
    import efr_pkg::*;
#(
    parameter logic [7:0] LAST_ADDR = 8'h1F  // Highest valid address
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    input  wire logic [EFR_FLAG_W-1:0] i_err_en,
    input  wire logic                  i_reg_wr,
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [EFR_REG_W-1:0]  i_reg_wdata,
    input  wire logic                  i_access,
    input  wire logic                  i_ignoring,
    input  wire logic                  i_frame_end,
    input  wire logic [2:0]            i_frame_bits,
    input  wire logic                  i_rd_cmd,
    input  wire logic                  i_wr_cmd,
    input  wire logic [7:0]            i_cmd_addr,
    input  wire logic                  i_clamp_pos,
    input  wire logic [EFR_FLAG_W-1:0] o_err_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Clear strobe actually taken this cycle
    wire logic clr_wr = i_ce && i_reg_wr && i_reg_addr == EFR_ERR_ADDR;
    property p_ign; i_ce && i_access && i_ignoring && i_err_en[6]
        |=> o_err_flags[6]; endproperty
    a_ign: assert property (p_ign) else $error("ignore flag missed");
    property p_cnt; i_ce && i_frame_end && i_frame_bits != 3'h0
        && i_err_en[5] |=> o_err_flags[5]; endproperty
    a_cnt: assert property (p_cnt) else $error("count flag missed");
    property p_rd; i_ce && i_rd_cmd && i_cmd_addr > LAST_ADDR
        && i_err_en[4] |=> o_err_flags[4]; endproperty
    a_rd: assert property (p_rd) else $error("read flag missed");
    property p_wr; i_ce && i_wr_cmd && i_cmd_addr > LAST_ADDR
        && i_err_en[3] |=> o_err_flags[3]; endproperty
    a_wr: assert property (p_wr) else $error("write flag missed");
    property p_conv; i_ce && i_clamp_pos && i_err_en[7]
        |=> o_err_flags[7]; endproperty
    a_conv: assert property (p_conv) else $error("conv flag missed");
    // With every enable off nothing can set, so a clear must land
    property p_clr; clr_wr && i_err_en == 8'h00
        |=> (o_err_flags & $past(i_reg_wdata[7:0])) == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("clear not taken");
    property p_en; i_err_en == 8'h00
        |=> (o_err_flags & ~$past(o_err_flags)) == 8'h00; endproperty
    a_en: assert property (p_en) else $error("disabled flag rose");
    property p_stick; !clr_wr
        |=> ($past(o_err_flags) & ~o_err_flags) == 8'h00; endproperty
    a_stick: assert property (p_stick) else $error("flag dropped");
endmodule : efr_error_flags_chk

bind efr_error_flags efr_error_flags_chk #(.LAST_ADDR(LAST_ADDR)) i_chk (
    .i_clk_sys, .i_rst_n, .i_ce, .i_err_en, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .i_access, .i_ignoring, .i_frame_end, .i_frame_bits,
    .i_rd_cmd, .i_wr_cmd, .i_cmd_addr, .i_clamp_pos, .o_err_flags);

/* File: bench/efr_host_model.sv */
// Host side model: serial events and error register writes
module efr_host_model
    import efr_pkg::*;
(
    output logic        o_acc,     // Frame began
    output logic        o_ign,     // Accesses ignored now
    output logic        o_fend,    // Chip select released
    output logic        o_rd,      // Read command decoded
    output logic        o_wr,      // Write command decoded
    output logic        o_crc,     // Frame checksum failed
    output logic        o_done,    // ROM check finished
    output logic        o_ok,      // ROM check passed
    output logic        o_cp,      // Clamp at positive full scale
    output logic        o_cn,      // Clamp at negative full scale
    output logic        o_cal,     // Calibration out of range
    output logic        o_sat,     // Modulator saturated
    output logic        o_reg_wr,  // Register write strobe
    output logic [2:0]  o_bits,    // Frame clock count, low bits
    output logic [7:0]  o_caddr,   // Command address
    output logic [7:0]  o_raddr,   // Register write address
    output logic [15:0] o_wdata    // Register write data
);
    timeunit 1ns;
    timeprecision 1ns;
    // One cycle of traffic from a random word; zero gives a quiet cycle
    task automatic step(input logic [31:0] r);
        {o_acc, o_ign, o_fend, o_rd, o_wr, o_crc} = {r[0] & r[1], r[2],
            r[3] & r[4], r[8] & r[9], r[10] & r[11], r[18] & r[19]};
        {o_done, o_ok, o_cp, o_cn, o_cal, o_sat} = {r[20] & r[21], r[22],
            r[23] & r[24], r[25] & r[26], r[27] & r[28], r[29] & r[30]};
        o_bits = r[7:5];
        // Addresses straddle the last valid one on purpose
        o_caddr = r[12] ? (r[13] ? 8'h20 : 8'h1F) : {r[31:28], r[17:14]};
        o_reg_wr = r[31] & r[5];
        o_raddr = r[6] ? EFR_ERR_ADDR : 8'h07;
        o_wdata = r[15:0];
    endtask : step
    // One write-one-to-clear; a nonzero cnt ends a frame that many clocks
    // past a byte boundary in the same cycle, so set meets clear
    task automatic clear(input logic [15:0] d, input logic [2:0] cnt);
        {o_acc, o_ign, o_rd, o_wr, o_crc} = 5'h00;
        {o_done, o_ok, o_cp, o_cn, o_cal, o_sat} = 6'h00;
        {o_fend, o_bits, o_caddr} = {cnt != 3'h0, cnt, 8'h00};
        {o_reg_wr, o_raddr, o_wdata} = {1'b1, EFR_ERR_ADDR, d};
    endtask : clear
endmodule : efr_host_model

/* File: bench/test_efr_error_flags.sv */
// Self-checking bench for the error flag register
module test_efr_error_flags;
    import efr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_clk_sys  = 1'b0;
    logic       i_rst_n    = 1'b0;
    logic       i_ce       = 1'b1;
    logic [7:0] en         = 8'h00;  // Flag enables
    logic [7:0] map        = 8'hA5;  // Map contents under check
    logic [7:0] flags;               // Flag outputs
    logic [7:0] exp_r      = 8'h00;  // Expected flags
    int         error_cnt  = 0;
    int         n_compared = 0;
    wire logic        acc, ign, fend, rd, wr, crc; // Serial engine events
    wire logic        done, ok, cp, cn, cal, sat;  // ROM and conversion
    wire logic        reg_wr;                      // Register write strobe
    wire logic [2:0]  bits;                        // Frame clock count, low
    wire logic [7:0]  caddr, raddr;                // Command, register addr
    wire logic [15:0] wdata;                       // Register write data
    // Host model drives every serial and register input of the block
    efr_host_model i_host (
        .o_acc(acc), .o_ign(ign), .o_fend(fend), .o_rd(rd), .o_wr(wr),
        .o_crc(crc), .o_done(done), .o_ok(ok), .o_cp(cp), .o_cn(cn),
        .o_cal(cal), .o_sat(sat), .o_reg_wr(reg_wr), .o_bits(bits),
        .o_caddr(caddr), .o_raddr(raddr), .o_wdata(wdata));
    always #50 i_clk_sys = ~i_clk_sys;
    // Short map check so integrity passes come round quickly
    efr_error_flags #(.MAP_W(8), .PERIOD_CYC(4)) i_dut (
        .i_clk_sys, .i_rst_n, .i_ce, .i_err_en(en), .i_reg_wr(reg_wr),
        .i_reg_addr(raddr), .i_reg_wdata(wdata), .i_access(acc),
        .i_ignoring(ign), .i_frame_end(fend), .i_frame_bits(bits),
        .i_rd_cmd(rd), .i_wr_cmd(wr), .i_cmd_addr(caddr),
        .i_frame_crc_bad(crc), .i_rom_crc_done(done), .i_rom_crc_ok(ok),
        .i_clamp_pos(cp), .i_clamp_neg(cn), .i_cal_range(cal),
        .i_mod_sat(sat), .i_map(map), .o_err_flags(flags));
    // Flags that this cycle's events should raise; bit 1 is judged apart
    function automatic logic [7:0] set_of();
        set_of = en & {cp | cn | cal | sat, acc & ign, fend & (bits != 3'h0),
            rd & (caddr > 8'h1F), wr & (caddr > 8'h1F), crc, 1'b0,
            done & ~ok};
    endfunction : set_of
    // Reference register: set wins over a coincident clear
    always @(posedge i_clk_sys or negedge i_rst_n)
        if (!i_rst_n) exp_r <= 8'h00;
        else if (i_ce) exp_r <= (exp_r & ~((reg_wr && raddr == EFR_ERR_ADDR)
            ? wdata[7:0] : 8'h00)) | set_of();
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cyc();
        @(negedge i_clk_sys);
        check(flags & 8'h1C, exp_r & 8'h1C);
        check(flags & 8'hE1, exp_r & 8'hE1);
    endtask : cyc
    task automatic conclude();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
    initial begin
        void'($urandom(74917));
        i_host.step(32'h0000_0000);
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys) i_rst_n = 1'b1;
        en = 8'hFD;
        i_host.step(32'h0000_0018);
        cyc();
        i_host.step(32'h0000_0038);
        cyc();
        i_host.clear(16'h0020, 3'h1);
        cyc();
        i_host.clear(16'h0020, 3'h0);
        // Random traffic; map check kept off so bit 1 stays predictable
        repeat (3000) begin
            cyc();
            en = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom) & 8'hFD;
            i_ce = ($urandom % 16 != 0);
            i_host.step($urandom);
        end
        cyc();
        {en, i_ce} = {8'h02, 1'b1};
        i_host.step(32'h0000_0000);
        repeat (80) cyc();
        check(flags & 8'h02, 8'h00);
        map = 8'h5A;
        repeat (80) cyc();
        check(flags & 8'h02, 8'h02);
        en = 8'h00;
        i_host.clear(16'h0002, 3'h0);
        cyc();
        i_host.step(32'h0000_0000);
        cyc();
        check(flags & 8'h02, 8'h00);
        // Baseline on the new contents, then change them with a write
        en = 8'h02;
        repeat (40) cyc();
        map = 8'hA5;
        i_host.step(32'h8000_0020);
        cyc();
        i_host.step(32'h0000_0000);
        repeat (80) cyc();
        check(flags & 8'h02, 8'h00);
        conclude();
    end
endmodule : test_efr_error_flags
